// *** src/lrwpan_tx_framer_spreader.sv ***
// Transmit framer with chip spreading, a 128-byte frame store and a host input FIFO.
// Assumes all inputs are synchronous to ref_clk and strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module byte_skid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] next_store [DEPTH];
  logic [PW-1:0]    rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
  logic [CW-1:0]    cnt, next_cnt;
  logic             push, pop;

  assign out_data = store[rd_ptr];
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  always_comb begin
    next_store  = store;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_cnt    = cnt;
    if (push) begin
      next_store[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      store     <= '{default: '0};
      rd_ptr    <= '0;
      wr_ptr    <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      store     <= next_store;
      rd_ptr    <= next_rd_ptr;
      wr_ptr    <= next_wr_ptr;
      cnt       <= next_cnt;
      in_ready  <= next_cnt != CW'(DEPTH);
      out_valid <= next_cnt != '0;
    end
  end
endmodule

module lrwpan_tx_framer_spreader
  import lrwpan_tx_pkg::*;
#(
  parameter int TURN_CYCLES_P = lrwpan_tx_pkg::TURN_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire lrwpan_tx_pkg::strobe_t   cmd,
  input  wire lrwpan_tx_pkg::config_t   cfg,
  input  wire logic                     channel_clear,
  input  wire logic                     wr_valid,
  input  wire logic [7:0]               wr_byte,
  output var  logic                     wr_ready,
  output var  lrwpan_tx_pkg::chip_pair_t chips,
  output var  logic                     sfd_active,
  output var  logic                     sfd_event,
  output var  logic                     frame_sent_event,
  output var  logic                     tx_active,
  output var  logic                     rx_on,
  output var  logic                     overflow_flag,
  output var  logic                     underflow_flag,
  output var  logic                     latched_channel_clear,
  output var  logic [15:0]              receiver_enable_mask,
  output var  logic [7:0]               tx_fill_count
);
  import lrwpan_tx_pkg::*;

  localparam logic [6:0] CHIP_LAST = 7'(CHIP_CYCLES - 1);
  localparam logic [6:0] HALF_AT   = 7'(HALF_CHIP);
  localparam logic [2:0] PRE_LAST  = 3'(PRE_BYTES - 1);
  localparam logic [15:0] TURN_LOAD = 16'(TURN_CYCLES_P - 1);
  localparam logic [15:0] RAMP_LOAD = 16'(RAMP_CYCLES - 1);
  localparam logic [7:0] FULL_CNT  = 8'(FIFO_BYTES);
  localparam int TURN_LOAD_I = TURN_CYCLES_P - 1;
  localparam int RAMP_LOAD_I = RAMP_CYCLES - 1;

  function automatic logic chip_bit(input logic [3:0] s, input logic [4:0] i);
    return CHIP_TABLE[s][5'd31 - i];
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      r = (r[0] ^ b[k]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  phase_t     phase, next_phase;
  src_t       src, next_src;
  logic [2:0] pre_cnt, next_pre_cnt;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic [6:0] div_cnt, next_div_cnt;
  logic [4:0] chip_idx, next_chip_idx;
  logic       sym_hi, next_sym_hi;
  logic [7:0] cur_byte, next_cur_byte;
  logic [7:0] rd_ptr, next_rd_ptr;
  logic [7:0] sent_bytes, next_sent_bytes;
  logic [6:0] frame_len, next_frame_len;
  logic [15:0] crc, next_crc;
  logic [7:0] mem [FIFO_BYTES];
  logic [7:0] next_mem [FIFO_BYTES];
  logic       done_flag, next_done_flag;
  chip_pair_t next_chips;
  logic       next_sfd_active, next_sfd_event, next_frame_sent_event;
  logic       next_overflow_flag, next_underflow_flag, next_latched_channel_clear;
  logic [15:0] next_receiver_enable_mask;
  logic [7:0] next_tx_fill_count;
  logic       byte_done, more_data, fetch_now, drain_ready, q_valid, ramp_go;
  logic [7:0] q_byte, fetched;
  logic [3:0] sym;

  byte_skid_fifo #(.WIDTH(8), .DEPTH(IN_FIFO_DEPTH)) u_in_fifo (
    .clk      (ref_clk),
    .rst_b    (rst_b),
    .in_valid (wr_valid),
    .in_data  (wr_byte),
    .in_ready (wr_ready),
    .out_valid(q_valid),
    .out_data (q_byte),
    .out_ready(drain_ready)
  );

  assign sym       = sym_hi ? cur_byte[7:4] : cur_byte[3:0];
  assign byte_done = (phase == PH_SEND) && (div_cnt == CHIP_LAST) && (chip_idx == 5'd31) && sym_hi;
  assign more_data = cfg.auto_checksum ? (sent_bytes + 8'd2 < {1'b0, frame_len})
                                       : (sent_bytes < {1'b0, frame_len});
  assign fetch_now = byte_done && ((src == SRC_SFD) ||
                     ((src == SRC_LEN || src == SRC_DATA) && more_data));
  assign fetched   = mem[rd_ptr[6:0]];
  assign drain_ready = !fetch_now && !cmd.tx_fifo_flush_strobe;

  always_comb begin
    next_phase = phase;
    next_src = src;
    next_pre_cnt = pre_cnt;
    next_wait_cnt = wait_cnt;
    next_div_cnt = div_cnt;
    next_chip_idx = chip_idx;
    next_sym_hi = sym_hi;
    next_cur_byte = cur_byte;
    next_rd_ptr = rd_ptr;
    next_sent_bytes = sent_bytes;
    next_frame_len = frame_len;
    next_crc = crc;
    next_mem = mem;
    next_done_flag = done_flag;
    next_chips = chips;
    next_sfd_active = sfd_active;
    next_sfd_event = 1'b0;
    next_frame_sent_event = 1'b0;
    next_overflow_flag = overflow_flag;
    next_underflow_flag = underflow_flag;
    next_latched_channel_clear = latched_channel_clear;
    next_receiver_enable_mask = receiver_enable_mask;
    next_tx_fill_count = tx_fill_count;
    ramp_go = 1'b0;
    if (cmd.tx_fifo_flush_strobe) begin
      next_tx_fill_count = '0;
      next_overflow_flag = 1'b0;
      next_underflow_flag = 1'b0;
      next_done_flag = 1'b0;
    end
    if (q_valid && drain_ready && !overflow_flag) begin
      if (done_flag) begin
        next_mem[0] = q_byte;
        next_tx_fill_count = 8'd1;
        next_done_flag = 1'b0;
      end else if (tx_fill_count == FULL_CNT) begin
        next_overflow_flag = 1'b1;
      end else begin
        next_mem[tx_fill_count[6:0]] = q_byte;
        next_tx_fill_count = tx_fill_count + 8'd1;
      end
    end
    case (phase)
      PH_TURN: begin
        if (wait_cnt == '0) begin
          next_phase = PH_SEND;
          next_src = SRC_PRE;
          next_pre_cnt = '0;
          next_cur_byte = PRE_VALUE;
          next_div_cnt = '0;
          next_chip_idx = '0;
          next_sym_hi = 1'b0;
          next_rd_ptr = '0;
          next_sent_bytes = '0;
          next_crc = CRC_INIT;
        end else begin
          next_wait_cnt = wait_cnt - 16'd1;
        end
      end
      PH_SEND: begin
        next_div_cnt = (div_cnt == CHIP_LAST) ? '0 : div_cnt + 7'd1;
        if (div_cnt == '0 && !chip_idx[0]) begin
          next_chips.chip_i = chip_bit(sym, chip_idx);
        end
        if (div_cnt == HALF_AT && chip_idx[0]) begin
          next_chips.chip_q = chip_bit(sym, chip_idx);
        end
        if (div_cnt == CHIP_LAST) begin
          next_chip_idx = chip_idx + 5'd1;
          if (chip_idx == 5'd31) begin
            next_sym_hi = !sym_hi;
          end
        end
        if (byte_done) begin
          case (src)
            SRC_PRE: begin
              if (pre_cnt == PRE_LAST) begin
                next_src = SRC_SFD;
                next_cur_byte = SFD_VALUE;
              end else begin
                next_pre_cnt = pre_cnt + 3'd1;
                next_cur_byte = PRE_VALUE;
              end
            end
            SRC_SFD: begin
              next_sfd_event = 1'b1;
              next_sfd_active = 1'b1;
            end
            SRC_CRC_LO: begin
              next_src = SRC_CRC_HI;
              next_cur_byte = crc[15:8];
            end
            SRC_CRC_HI: ramp_go = 1'b1;
            default: begin
              if (!more_data) begin
                if (cfg.auto_checksum) begin
                  next_src = SRC_CRC_LO;
                  next_cur_byte = crc[7:0];
                end else begin
                  ramp_go = 1'b1;
                end
              end
            end
          endcase
          if (fetch_now) begin
            if (rd_ptr >= tx_fill_count && !cfg.underrun_suppress) begin
              next_underflow_flag = 1'b1;
              ramp_go = 1'b1;
            end else begin
              next_cur_byte = fetched;
              next_rd_ptr = rd_ptr + 8'd1;
              if (src == SRC_SFD) begin
                next_src = SRC_LEN;
                next_frame_len = fetched[6:0];
              end else begin
                next_src = SRC_DATA;
                next_sent_bytes = sent_bytes + 8'd1;
                next_crc = crc_step(crc, fetched);
              end
            end
          end
        end
        if (ramp_go) begin
          next_phase = PH_RAMP;
          next_wait_cnt = RAMP_LOAD;
        end
      end
      PH_RAMP: begin
        if (wait_cnt == '0) begin
          next_sfd_active = 1'b0;
          if (!underflow_flag) begin
            next_frame_sent_event = 1'b1;
            next_done_flag = 1'b1;
          end
          if (receiver_enable_mask != '0) begin
            next_phase = PH_RXCAL;
            next_wait_cnt = TURN_LOAD;
          end else begin
            next_phase = PH_IDLE;
          end
        end else begin
          next_wait_cnt = wait_cnt - 16'd1;
        end
      end
      PH_RXCAL: begin
        if (wait_cnt == '0) begin
          next_phase = PH_RX;
        end else begin
          next_wait_cnt = wait_cnt - 16'd1;
        end
      end
      PH_RX: begin
        if (receiver_enable_mask == '0) begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = phase;
      end
    endcase
    if (cmd.tx_go_if_clear_strobe) begin
      next_latched_channel_clear = channel_clear;
    end
    if (cmd.radio_off_strobe) begin
      next_phase = PH_IDLE;
      next_receiver_enable_mask = '0;
      next_sfd_active = 1'b0;
    end else if (cmd.rx_go_strobe) begin
      next_phase = PH_RXCAL;
      next_wait_cnt = TURN_LOAD;
      next_receiver_enable_mask[MASK_RX_BIT] = 1'b1;
      next_sfd_active = 1'b0;
    end else if (cmd.tx_go_strobe || (cmd.tx_go_if_clear_strobe && channel_clear)) begin
      next_phase = PH_TURN;
      next_wait_cnt = TURN_LOAD;
      next_sfd_active = 1'b0;
      if (cmd.tx_go_strobe && cfg.rx_after_tx_setting) begin
        next_receiver_enable_mask[MASK_TX_BIT] = 1'b1;
      end
    end else if (cmd.tx_fifo_flush_strobe && phase == PH_SEND) begin
      next_underflow_flag = 1'b1;
      next_phase = PH_RAMP;
      next_wait_cnt = RAMP_LOAD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase <= PH_IDLE;
      src <= SRC_PRE;
      pre_cnt <= '0;
      wait_cnt <= '0;
      div_cnt <= '0;
      chip_idx <= '0;
      sym_hi <= 1'b0;
      cur_byte <= '0;
      rd_ptr <= '0;
      sent_bytes <= '0;
      frame_len <= '0;
      crc <= CRC_INIT;
      mem <= '{default: 8'h00};
      done_flag <= 1'b0;
      chips <= '0;
      sfd_active <= 1'b0;
      sfd_event <= 1'b0;
      frame_sent_event <= 1'b0;
      tx_active <= 1'b0;
      rx_on <= 1'b0;
      overflow_flag <= 1'b0;
      underflow_flag <= 1'b0;
      latched_channel_clear <= 1'b0;
      receiver_enable_mask <= '0;
      tx_fill_count <= '0;
    end else begin
      phase <= next_phase;
      src <= next_src;
      pre_cnt <= next_pre_cnt;
      wait_cnt <= next_wait_cnt;
      div_cnt <= next_div_cnt;
      chip_idx <= next_chip_idx;
      sym_hi <= next_sym_hi;
      cur_byte <= next_cur_byte;
      rd_ptr <= next_rd_ptr;
      sent_bytes <= next_sent_bytes;
      frame_len <= next_frame_len;
      crc <= next_crc;
      mem <= next_mem;
      done_flag <= next_done_flag;
      chips <= next_chips;
      sfd_active <= next_sfd_active;
      sfd_event <= next_sfd_event;
      frame_sent_event <= next_frame_sent_event;
      tx_active <= (next_phase == PH_SEND) || (next_phase == PH_RAMP);
      rx_on <= next_phase == PH_RX;
      overflow_flag <= next_overflow_flag;
      underflow_flag <= next_underflow_flag;
      latched_channel_clear <= next_latched_channel_clear;
      receiver_enable_mask <= next_receiver_enable_mask;
      tx_fill_count <= next_tx_fill_count;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_low_first;
    (phase == PH_SEND && div_cnt == CHIP_LAST && chip_idx == 5'd31 && !sym_hi)
      |=> sym_hi && $stable(cur_byte);
  endproperty
  a_low_first: assert property (p_low_first) else $error("High symbol sent early.");

  property p_chip_i;
    (phase == PH_SEND && div_cnt == '0 && !chip_idx[0])
      |=> chips.chip_i == CHIP_TABLE[$past(sym)][5'd31 - $past(chip_idx)];
  endproperty
  a_chip_i: assert property (p_chip_i) else $error("Wrong in-phase chip.");

  property p_q_skew;
    $changed(chips.chip_q) |-> $past(div_cnt) == HALF_AT && $past(chip_idx[0]);
  endproperty
  a_q_skew: assert property (p_q_skew) else $error("Quadrature chip off its half slot.");

  property p_sfd_value;
    (src == SRC_SFD && $past(src) == SRC_PRE)
      |-> cur_byte == SFD_VALUE && $past(pre_cnt) == PRE_LAST;
  endproperty
  a_sfd_value: assert property (p_sfd_value) else $error("Delimiter misplaced.");

  property p_tx_keep_latch;
    cmd.tx_go_strobe && !cmd.tx_go_if_clear_strobe |=> $stable(latched_channel_clear);
  endproperty
  a_tx_keep_latch: assert property (p_tx_keep_latch) else $error("Latch moved.");

  property p_cond_tx;
    cmd.tx_go_if_clear_strobe && !cmd.radio_off_strobe && !cmd.rx_go_strobe
      |=> latched_channel_clear == $past(channel_clear)
          && ((phase == PH_TURN && wait_cnt == TURN_LOAD)
              == $past(channel_clear || cmd.tx_go_strobe));
  endproperty
  a_cond_tx: assert property (p_cond_tx) else $error("Conditional start wrong.");

  property p_off;
    cmd.radio_off_strobe |=> phase == PH_IDLE && receiver_enable_mask == '0 && !tx_active;
  endproperty
  a_off: assert property (p_off) else $error("Off strobe ignored.");

  property p_rx_mask;
    cmd.tx_go_strobe && cfg.rx_after_tx_setting && !cmd.radio_off_strobe && !cmd.rx_go_strobe
      |=> receiver_enable_mask[MASK_TX_BIT];
  endproperty
  a_rx_mask: assert property (p_rx_mask) else $error("Mask bit not set.");

  property p_turn_load;
    (phase == PH_TURN && $past(phase) != PH_TURN) |-> wait_cnt == 16'(TURN_LOAD_I);
  endproperty
  a_turn_load: assert property (p_turn_load) else $error("Turnaround count wrong.");

  property p_ramp;
    (phase == PH_RAMP && $past(phase) != PH_RAMP)
      |-> wait_cnt == 16'(RAMP_LOAD_I) && (sfd_active || !$past(sfd_active));
  endproperty
  a_ramp: assert property (p_ramp) else $error("Ramp entry wrong.");

  property p_count_max;
    tx_fill_count <= FULL_CNT;
  endproperty
  a_count_max: assert property (p_count_max) else $error("Count past capacity.");

  property p_flush_send;
    cmd.tx_fifo_flush_strobe && phase == PH_SEND && !cmd.tx_go_strobe
      && !cmd.tx_go_if_clear_strobe && !cmd.rx_go_strobe && !cmd.radio_off_strobe
      |=> underflow_flag && tx_fill_count == '0 && phase == PH_RAMP;
  endproperty
  a_flush_send: assert property (p_flush_send) else $error("Flush did not abort.");

  property p_overflow;
    q_valid && drain_ready && !overflow_flag && !done_flag && tx_fill_count == FULL_CNT
      |=> overflow_flag && tx_fill_count == FULL_CNT;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow missed.");

  c_frame_sent: cover property (frame_sent_event);
  c_underflow: cover property ($rose(underflow_flag) && phase == PH_RAMP);
  c_overflow: cover property ($rose(overflow_flag));
  c_rx_entered: cover property ($rose(rx_on));
endmodule

`default_nettype wire

// *** src/lrwpan_tx_pkg.sv ***
// Constants, types and carriers shared by the transmit framer.
// Assumes a single 200 MHz core clock.
package lrwpan_tx_pkg;
  localparam int CLK_MHZ         = 200;
  localparam int TURN_US         = 192;
  localparam int TURN_CYCLES     = TURN_US * CLK_MHZ;
  localparam int RAMP_US         = 2;
  localparam int RAMP_CYCLES     = RAMP_US * CLK_MHZ;
  localparam int CHIP_RATE_KHZ   = 2000;
  localparam int CHIP_CYCLES     = CLK_MHZ * 1000 / CHIP_RATE_KHZ;
  localparam int HALF_CHIP       = CHIP_CYCLES / 2;
  localparam int PRE_BYTES       = 4;
  localparam logic [7:0]  PRE_VALUE  = 8'h00;
  localparam logic [7:0]  SFD_VALUE  = 8'hA7;
  localparam int FIFO_BYTES      = 128;
  localparam int IN_FIFO_DEPTH   = 4;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  localparam int MASK_TX_BIT     = 14;
  localparam int MASK_RX_BIT     = 15;
  localparam logic [31:0] CHIP_TABLE [16] = '{
    32'hD9C3522E, 32'hED9C3522, 32'h2ED9C352, 32'h22ED9C35,
    32'h522ED9C3, 32'h3522ED9C, 32'hC3522ED9, 32'h9C3522ED,
    32'h8C96077B, 32'hB8C96077, 32'h7B8C9607, 32'h77B8C960,
    32'h077B8C96, 32'h6077B8C9, 32'h96077B8C, 32'hC96077B8};

  typedef enum logic [2:0] {PH_IDLE, PH_TURN, PH_SEND, PH_RAMP, PH_RXCAL, PH_RX} phase_t;
  typedef enum logic [2:0] {SRC_PRE, SRC_SFD, SRC_LEN, SRC_DATA, SRC_CRC_LO, SRC_CRC_HI} src_t;

  typedef struct packed {
    logic tx_go_strobe;
    logic tx_go_if_clear_strobe;
    logic rx_go_strobe;
    logic radio_off_strobe;
    logic tx_fifo_flush_strobe;
  } strobe_t;

  typedef struct packed {
    logic auto_checksum;
    logic underrun_suppress;
    logic rx_after_tx_setting;
  } config_t;

  typedef struct packed {
    logic chip_i;
    logic chip_q;
  } chip_pair_t;
endpackage

// *** tb/lrwpan_host_model.sv ***
// Host model that loads frame bytes and issues command strobes.
// Assumes the framer takes a byte at a rising edge with wr_ready high.
`timescale 1ns/1ps
`default_nettype none
module lrwpan_host_model
  import lrwpan_tx_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   wr_ready,
  output var  logic                   wr_valid,
  output var  logic [7:0]             wr_byte,
  output var  lrwpan_tx_pkg::strobe_t cmd
);
  initial begin
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    cmd = '0;
  end
  // Bytes enter through the dedicated write path only.
  task automatic put_byte(input logic [7:0] b);
    @(negedge ref_clk);
    wr_valid = 1'b1;
    wr_byte = b;
    for (int i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (wr_ready) break;
    end
    @(negedge ref_clk);
    wr_valid = 1'b0;
    wr_byte = ~b;
  endtask
  task automatic pulse(input int idx);
    @(negedge ref_clk);
    cmd = strobe_t'(5'h01 << idx);
    @(negedge ref_clk);
    cmd = '0;
  endtask
endmodule
`default_nettype wire

// *** tb/lrwpan_tx_framer_spreader_tb.sv ***
// Self-checking bench for the transmit framer, driven through the host model.
// Assumes a turnaround shortened to 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module lrwpan_tx_framer_spreader_tb;
  import lrwpan_tx_pkg::*;
  localparam int TURN = 40;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        channel_clear = 1'b0;
  config_t     cfg = '0;
  strobe_t     cmd;
  chip_pair_t  chips;
  logic        wr_valid, wr_ready, sfd_active, sfd_event, frame_sent_event, tx_active, rx_on;
  logic        overflow_flag, underflow_flag, latched_channel_clear;
  logic [7:0]  wr_byte, tx_fill_count;
  logic [15:0] receiver_enable_mask;
  int          mismatches = 0, tests_run = 0, sfd_seen = 0, sent_seen = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sfd_event) sfd_seen <= sfd_seen + 1;
  always @(posedge ref_clk) if (frame_sent_event) sent_seen <= sent_seen + 1;
  lrwpan_host_model u_host (.ref_clk(ref_clk), .wr_ready(wr_ready), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .cmd(cmd));
  lrwpan_tx_framer_spreader #(.TURN_CYCLES_P(TURN)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .cfg(cfg), .channel_clear(channel_clear),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ready(wr_ready), .chips(chips),
    .sfd_active(sfd_active), .sfd_event(sfd_event), .frame_sent_event(frame_sent_event),
    .tx_active(tx_active), .rx_on(rx_on), .overflow_flag(overflow_flag),
    .underflow_flag(underflow_flag), .latched_channel_clear(latched_channel_clear),
    .receiver_enable_mask(receiver_enable_mask), .tx_fill_count(tx_fill_count));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_for(input int idx, input int bound);
    logic [3:0] evs;
    for (int i = 0; i <= bound; i++) begin
      @(negedge ref_clk);
      evs = {underflow_flag, rx_on, frame_sent_event, tx_active};
      if (evs[idx] === 1'b1) return;
    end
    mismatches++;
    $display("BAD wait%0d expected 1 seen 0", idx);
    conclude();
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction
  initial begin
    logic [7:0]  p;
    logic [7:0]  fr [9];
    logic [15:0] crc;
    int          k;
    void'($urandom(32'h6f34));
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    p = 8'($urandom);
    u_host.put_byte(8'h03);
    u_host.put_byte(p);
    u_host.put_byte(8'($urandom));
    repeat (4) @(negedge ref_clk);
    check("fill", 16'h0003, {8'h00, tx_fill_count});
    cfg = 3'h5;
    u_host.pulse(4);
    @(negedge ref_clk);
    check("mask14", 16'h4000, receiver_enable_mask);
    check("latched", 16'h0000, {15'h0000, latched_channel_clear});
    repeat (TURN - 3) @(negedge ref_clk);
    check("early", 16'h0000, {15'h0000, tx_active});
    wait_for(0, 6);
    crc = crc_byte(CRC_INIT, p);
    fr = '{8'h00, 8'h00, 8'h00, 8'h00, SFD_VALUE, 8'h03, p, crc[7:0], crc[15:8]};
    repeat (75) @(negedge ref_clk);
    for (k = 0; k < 576; k++) begin
      check("chip", {15'h0000, CHIP_TABLE[k[5] ? fr[k / 64][7:4] : fr[k / 64][3:0]][31 - k % 32]},
            {15'h0000, k[0] ? chips.chip_q : chips.chip_i});
      repeat (100) @(negedge ref_clk);
    end
    check("ramp", 16'h0003, {14'h0000, sfd_active, tx_active});
    wait_for(1, 400);
    check("sfd", 16'h0001, 16'(sfd_seen));
    wait_for(2, TURN + 10);
    $display("end frame");
    u_host.pulse(1);
    repeat (2) @(negedge ref_clk);
    check("off", 16'h0000, receiver_enable_mask | {15'h0000, rx_on});
    check("kept", 16'h0003, {8'h00, tx_fill_count});
    u_host.put_byte(8'($urandom));
    repeat (4) @(negedge ref_clk);
    check("restart", 16'h0001, {8'h00, tx_fill_count});
    u_host.pulse(0);
    for (k = 0; k < 129; k++) u_host.put_byte(8'($urandom));
    repeat (8) @(negedge ref_clk);
    check("full", 16'h0180, {7'h00, overflow_flag, tx_fill_count});
    u_host.pulse(0);
    repeat (2) @(negedge ref_clk);
    check("flushed", 16'h0000, {7'h00, overflow_flag, tx_fill_count});
    u_host.pulse(2);
    wait_for(2, TURN + 5);
    check("rxmask", 16'h8000, receiver_enable_mask);
    u_host.pulse(1);
    $display("end store");
    u_host.pulse(3);
    repeat (TURN + 10) @(negedge ref_clk);
    check("busy", 16'h0000, {14'h0000, latched_channel_clear, tx_active});
    channel_clear = 1'b1;
    cfg = 3'h0;
    u_host.pulse(3);
    @(negedge ref_clk);
    check("latch", 16'h0001, {15'h0000, latched_channel_clear});
    wait_for(0, TURN + 5);
    wait_for(3, 32100);
    repeat (420) @(negedge ref_clk);
    check("sfd2", 16'h0002, 16'(sfd_seen));
    check("nosent", 16'h0001, {tx_active, 15'(sent_seen)});
    u_host.pulse(0);
    check("cleared", 16'h0000, {15'h0000, underflow_flag});
    cfg = 3'h2;
    u_host.pulse(4);
    wait_for(0, TURN + 5);
    u_host.pulse(0);
    wait_for(3, 4);
    repeat (420) @(negedge ref_clk);
    check("abort", 16'h0001, {tx_active, 15'(sent_seen)});
    u_host.pulse(1);
    $display("end abort");
    conclude();
  end
endmodule
`default_nettype wire
